// *** common/gauge_map.svh ***
/*
 Register offsets, field positions, reset values, commands and timing
 counts shared by the gauge device end and the host controller end.
 Assumes a 200 MHz system clock and byte addresses on the serial link.
*/
`ifndef GAUGE_MAP_SVH
`define GAUGE_MAP_SVH

// Clock period and serial timing
`define CLK_NS 5
`define I2C_BIT_NS 2500
// Quarter of one serial bit, least time so rounded up
`define I2C_QUARTER_CYC ((`I2C_BIT_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
// Least low time before a wake edge counts
`define WAKE_LOW_NS 1000
`define WAKE_LOW_CYC ((`WAKE_LOW_NS + `CLK_NS - 1) / `CLK_NS)

// Fixed seven-bit target address
`define TARGET_ADDR 7'h55

// Device register byte offsets
`define OFS_COMMAND_CONTROL 8'h00
`define OFS_BATTERY_CURRENT 8'h04
`define OFS_THERMAL_READING 8'h06
`define OFS_CELL_VOLTAGE 8'h08
`define OFS_ALERT_STATUS_ONE 8'h0a
`define OFS_ALERT_STATUS_TWO 8'h0c
`define OFS_PART_IDENTIFIER 8'h0e
`define OFS_REMAINING_CHARGE 8'h10
`define OFS_FULL_CAPACITY 8'h12
`define OFS_MEAN_CURRENT 8'h14
`define OFS_RUNTIME_LEFT 8'h16
`define OFS_ALERT_ENABLE 8'h18
`define OFS_IRQ_ENABLE 8'h1a
`define OFS_REVISION_NUMBER 8'h20
`define OFS_GAUGE_COMP_A 8'h24
`define OFS_GAUGE_COMP_B 8'h26
`define OFS_DIE_THERMAL 8'h28
`define OFS_CHARGE_ROUND_TALLY 8'h2a
`define OFS_CHARGE_PERCENT 8'h2c
`define OFS_HEALTH_PERCENT 8'h2e
`define OFS_ALERT_STATUS_THREE 8'h30
`define OFS_INTERRUPT_PENDING 8'h36
`define OFS_DESIGN_CAPACITY 8'h3c
`define OFS_EXTENDED_COMMAND 8'h3e
`define EXT_WORDS_PAGE 4'h4
`define OFS_EXT_PAGE_SUM 8'h50
`define OFS_MEAN_VOLTAGE 8'h64
`define OFS_MEAN_THERMAL 8'h66
`define OFS_EXT_OVERALL_SUM 8'h68

// Device register reset values
`define RST_ZERO 16'h0000
`define RST_THERMAL 16'h0ba6
`define RST_VOLTAGE 16'h0ed8
`define RST_REMAINING 16'h03e8
`define RST_CAPACITY 16'h07d0
`define RST_ALL_ONES 16'hffff
`define RST_COMP 16'h3232
`define RST_CHARGE_PERCENT 16'h0032
`define RST_HEALTH_PERCENT 16'h0064

// Alert bit positions in status, enable and pending words
`define ALERT_COUNT 9
`define BIT_HOT_CHARGING 0
`define BIT_HOT_DISCHARGING 1
`define BIT_HIGH_VOLTAGE 2
`define BIT_LOW_VOLTAGE 3
`define BIT_LOW_CHARGE_LEVEL 4
`define BIT_CHARGE_LEVEL_STEP 5
`define BIT_EXCESS_CHARGE_CUR 6
`define BIT_EXCESS_DISCHARGE_CUR 7
`define BIT_THERMAL_STEP 8
// Event-type alerts: charge level step and thermal step
`define ALERT_EVENT_MASK 9'h120

// Shutdown commands to command_control, low bit picks wake pin
`define CMD_SHUTDOWN_SCL 16'h0010
`define CMD_SHUTDOWN_ALERT 16'h0011

// Host controller command port
`define HOST_OFS_CMD 4'h0
`define HOST_OFS_WDATA 4'h4
`define HOST_OFS_STATUS 4'h8
`define HOST_OFS_RDATA 4'hc
`define HCMD_READ 8
`define HCMD_GO 9
`define HCMD_WAKE_SCL 10
`define HCMD_WAKE_ALERT 11

`endif

// *** common/gauge_pkg.sv ***
/*
 Types of the gauge alert link: state enums and the packed state
 records of both ends. Assumes gauge_map.svh for the field widths.
*/
`default_nettype none
package gauge_pkg;

	// Target serial engine states
	typedef enum logic [2:0] {
		ts_idle, ts_addr, ts_addr_ack, ts_wr, ts_wr_ack, ts_rd, ts_rd_ack
	} target_st_t;

	// Host serial engine states
	typedef enum logic [2:0] {
		hs_idle, hs_start, hs_bit, hs_stop, hs_wake
	} host_st_t;

	// Whole device state
	typedef struct packed {
		target_st_t st;
		logic scl_q;
		logic sda_q;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic rw;
		logic first;
		logic [7:0] ptr;
		logic [7:0] wlo;
		logic [15:0] rdw;
		logic [7:0] tx;
		logic sda_oe;
		logic [15:0] ctrl;
		logic [15:0] therm;
		logic [15:0] comp_a;
		logic [15:0] comp_b;
		logic [15:0] tally;
		logic [7:0][15:0] ext;
		logic [8:0] alert_en;
		logic [8:0] irq_en;
		logic [8:0] flag;
		logic [8:0] irq;
		logic asleep;
		logic sleep_pend;
		logic wake_sel;
		logic pin_q;
		logic [15:0] low_cnt;
	} dev_state_t;

	// Whole host state
	typedef struct packed {
		host_st_t st;
		logic [1:0] ph;
		logic [7:0] div;
		logic [3:0] bit_i;
		logic [2:0] idx;
		logic op_rd;
		logic [7:0] ptr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [7:0] sh;
		logic scl_oe;
		logic sda_oe;
		logic alert_oe;
		logic nack;
		logic [15:0] wake_cnt;
		logic [15:0] rd_out;
	} host_state_t;

endpackage : gauge_pkg
`default_nettype wire

// *** common/gauge_link_if.sv ***
/*
 Serial clock, serial data and alert wires between host and gauge.
 Every line is open drain with a pull-up: low while any party enables.
*/
`timescale 1ns/100ps
`default_nettype none
interface gauge_link_if;
	// Host drives
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic host_alert_out;
	logic host_alert_oe;
	// Device drives
	logic dev_sda_out;
	logic dev_sda_oe;
	logic dev_alert_out;
	logic dev_alert_oe;
	// Resolved wire levels
	logic scl_line;
	logic sda_line;
	logic alert_line;

	// Wired-and of every enabled driver, pull-up otherwise
	assign scl_line = ~(host_scl_oe & ~host_scl_out);
	assign sda_line = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
	assign alert_line = ~((host_alert_oe & ~host_alert_out) | (dev_alert_oe & ~dev_alert_out));

	modport device (
		input scl_line, sda_line, alert_line,
		output dev_sda_out, dev_sda_oe, dev_alert_out, dev_alert_oe
	);
	modport host (
		input scl_line, sda_line, alert_line,
		output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe, host_alert_out, host_alert_oe
	);
endinterface : gauge_link_if
`default_nettype wire

// *** logic/gauge_alert_dev.sv ***
/*
 Gauge device end: serial target, register map, alert flags, pending
 interrupts, open-drain alert pin and shutdown with pin wake-up.
 Assumes link lines synchronous to clk_in and a host no faster than fast mode.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gauge_map.svh"

// How it works
// R1 - Disabled alert holds its flag clear
// R2 - Enabled alert sets flag on condition
// R3 - Level flags clear when condition ends
// R4 - Step flags stay until host writes zero
// R5 - Enabling interrupt on set flag raises nothing
// R6 - Level flag change either way raises interrupt
// R7 - Step flag rising raises interrupt when enabled
// R8 - Only reading pending register releases interrupts
// R9 - That read also clears step flags whose interrupt is pending
// R10 - Dropping interrupt enable keeps pending and pin
// R11 - Dropping alert enable clears its flag
// R12 - Host arms alerts through enable bits
// R13 - Host polls flags or watches alert pin
// R14 - Answer only the fixed target address
// R15 - Link runs at fast-mode rate, no faster
// R16 - Shutdown command picks the wake pin
// R17 - Wake on rise after long enough low
// R18 - Nine alert sources, two of them steps
// R19 - Alert pin open drain, low while pending, released in shutdown
module gauge_alert_dev #(
	parameter logic [15:0] PART_ID = 16'h0a5c, // Arbitrary value
	parameter logic [15:0] REVISION = 16'h0007, // Arbitrary value
	parameter logic [15:0] WAKE_CYC = 16'(`WAKE_LOW_CYC)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [`ALERT_COUNT-1:0] cond_in, // Levels, step bits are pulses
	output logic shutdown_out,
	gauge_link_if.device link
);

	localparam logic [8:0] EVT = `ALERT_EVENT_MASK; // R18

	gauge_pkg::dev_state_t s_reg; // Registered state
	gauge_pkg::dev_state_t s_next; // Next state
	gauge_pkg::dev_state_t rst_v; // Power-on state

	// Register word seen at a byte pointer
	function automatic logic [15:0] word_at(input gauge_pkg::dev_state_t s, input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:1], 1'b0};
		case (w)
			`OFS_COMMAND_CONTROL: word_at = s.ctrl;
			`OFS_THERMAL_READING: word_at = s.therm;
			`OFS_CELL_VOLTAGE, `OFS_MEAN_VOLTAGE: word_at = `RST_VOLTAGE;
			`OFS_ALERT_STATUS_ONE: word_at = {7'h00, s.flag}; // R13
			`OFS_PART_IDENTIFIER: word_at = PART_ID;
			`OFS_REMAINING_CHARGE: word_at = `RST_REMAINING;
			`OFS_FULL_CAPACITY, `OFS_DESIGN_CAPACITY: word_at = `RST_CAPACITY;
			`OFS_RUNTIME_LEFT, `OFS_EXT_PAGE_SUM: word_at = `RST_ALL_ONES;
			`OFS_ALERT_ENABLE: word_at = {7'h00, s.alert_en};
			`OFS_IRQ_ENABLE: word_at = {7'h00, s.irq_en};
			`OFS_REVISION_NUMBER: word_at = REVISION;
			`OFS_GAUGE_COMP_A: word_at = s.comp_a;
			`OFS_GAUGE_COMP_B: word_at = s.comp_b;
			`OFS_DIE_THERMAL, `OFS_MEAN_THERMAL: word_at = `RST_THERMAL;
			`OFS_CHARGE_ROUND_TALLY: word_at = s.tally;
			`OFS_CHARGE_PERCENT: word_at = `RST_CHARGE_PERCENT;
			`OFS_HEALTH_PERCENT: word_at = `RST_HEALTH_PERCENT;
			`OFS_INTERRUPT_PENDING: word_at = {7'h00, s.irq};
			// Fixed measurements, unused status words, write-only command
			default: word_at = (a[7:4] == `EXT_WORDS_PAGE) ? s.ext[a[3:1]] : `RST_ZERO;
		endcase
	endfunction : word_at

	// Power-on and wake-up values
	always_comb begin
		rst_v = '0;
		rst_v.st = gauge_pkg::ts_idle;
		rst_v.scl_q = 1'b1;
		rst_v.sda_q = 1'b1;
		rst_v.pin_q = 1'b1;
		rst_v.therm = `RST_THERMAL;
		rst_v.comp_a = `RST_COMP;
		rst_v.comp_b = `RST_COMP;
		rst_v.ext = {8{`RST_ALL_ONES}};
	end

	// Whole next-state function
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_seen;
		logic stop_seen;
		logic load;
		logic wr_en;
		logic wake;
		logic pin;
		logic [7:0] wa;
		logic [15:0] wd;
		logic [15:0] rw_word;
		logic [7:0] tx_byte;
		logic [8:0] sw_clr;
		logic [8:0] rd_clr;
		logic [8:0] lvl;
		logic [8:0] evt;
		logic [8:0] irq_set;
		s_next = s_reg;
		scl_rise = link.scl_line & ~s_reg.scl_q;
		scl_fall = ~link.scl_line & s_reg.scl_q;
		start_seen = s_reg.scl_q & link.scl_line & s_reg.sda_q & ~link.sda_line;
		stop_seen = s_reg.scl_q & link.scl_line & ~s_reg.sda_q & link.sda_line;
		load = 1'b0;
		wr_en = 1'b0;
		wake = 1'b0;
		pin = s_reg.wake_sel ? link.alert_line : link.scl_line;
		wa = {s_reg.ptr[7:1], 1'b0};
		wd = {s_reg.shift, s_reg.wlo};
		rw_word = '0;
		tx_byte = '0;
		sw_clr = '0;
		rd_clr = '0;
		// Filled after the bus logic, defaulted here so no path is left open
		lvl = '0;
		evt = '0;
		irq_set = '0;
		s_next.scl_q = link.scl_line;
		s_next.sda_q = link.sda_line;
		s_next.pin_q = pin;

		if (s_reg.asleep) begin
			// Serial engine idle; watch the chosen pin only
			s_next.low_cnt = pin ? 16'h0000 : (s_reg.low_cnt == 16'hffff ? s_reg.low_cnt : 16'(s_reg.low_cnt + 1)); // R17
			wake = pin & ~s_reg.pin_q & (s_reg.low_cnt >= WAKE_CYC); // R16 R17
		end else if (start_seen) begin
			// Start or repeated start
			s_next.st = gauge_pkg::ts_addr;
			s_next.cnt = '0;
			s_next.sda_oe = 1'b0;
		end else if (stop_seen) begin
			// End of frame; a pending shutdown takes effect here
			s_next.st = gauge_pkg::ts_idle;
			s_next.sda_oe = 1'b0;
			s_next.asleep = s_reg.sleep_pend;
			s_next.low_cnt = '0;
		end else if (scl_rise) begin
			// Sample data on the rising serial clock
			case (s_reg.st)
				gauge_pkg::ts_addr, gauge_pkg::ts_wr: begin
					s_next.shift = {s_reg.shift[6:0], link.sda_line};
					s_next.cnt = 4'(s_reg.cnt + 1);
				end
				gauge_pkg::ts_rd: s_next.cnt = 4'(s_reg.cnt + 1);
				gauge_pkg::ts_rd_ack: s_next.shift[0] = link.sda_line; // Host ack, low means more
				default: ;
			endcase
		end else if (scl_fall) begin
			// Drive or release data on the falling serial clock
			case (s_reg.st)
				gauge_pkg::ts_addr: if (s_reg.cnt == 4'h8) begin
					if (s_reg.shift[7:1] == `TARGET_ADDR) begin // R14
						s_next.st = gauge_pkg::ts_addr_ack;
						s_next.sda_oe = 1'b1;
						s_next.rw = s_reg.shift[0];
					end else begin
						s_next.st = gauge_pkg::ts_idle; // R14
					end
				end
				gauge_pkg::ts_addr_ack: begin
					s_next.cnt = '0;
					if (s_reg.rw) begin
						s_next.st = gauge_pkg::ts_rd;
						load = 1'b1;
					end else begin
						s_next.st = gauge_pkg::ts_wr;
						s_next.sda_oe = 1'b0;
						s_next.first = 1'b1;
					end
				end
				gauge_pkg::ts_wr: if (s_reg.cnt == 4'h8) begin
					s_next.st = gauge_pkg::ts_wr_ack;
					s_next.sda_oe = 1'b1;
					if (s_reg.first) begin
						// First byte is the register pointer
						s_next.ptr = s_reg.shift;
						s_next.first = 1'b0;
					end else begin
						// Low byte waits, high byte commits the word
						s_next.wlo = s_reg.shift;
						wr_en = s_reg.ptr[0];
						s_next.ptr = 8'(s_reg.ptr + 1);
					end
				end
				gauge_pkg::ts_wr_ack: begin
					s_next.st = gauge_pkg::ts_wr;
					s_next.sda_oe = 1'b0;
					s_next.cnt = '0;
				end
				gauge_pkg::ts_rd: begin
					if (s_reg.cnt == 4'h8) begin
						s_next.st = gauge_pkg::ts_rd_ack;
						s_next.sda_oe = 1'b0;
					end else begin
						s_next.tx = {s_reg.tx[6:0], 1'b0};
						s_next.sda_oe = ~s_reg.tx[6];
					end
				end
				gauge_pkg::ts_rd_ack: begin
					if (!s_reg.shift[0]) begin
						s_next.st = gauge_pkg::ts_rd;
						s_next.cnt = '0;
						load = 1'b1;
					end else begin
						s_next.st = gauge_pkg::ts_idle;
					end
				end
				default: s_next.st = gauge_pkg::ts_idle;
			endcase
		end

		// Next read byte; the whole word is caught at the low byte
		if (load) begin
			rw_word = word_at(s_reg, s_reg.ptr);
			if (!s_reg.ptr[0]) begin
				s_next.rdw = rw_word;
				tx_byte = rw_word[7:0];
			end else begin
				tx_byte = s_reg.rdw[15:8];
			end
			s_next.tx = tx_byte;
			s_next.sda_oe = ~tx_byte[7];
			s_next.ptr = 8'(s_reg.ptr + 1);
			if (s_reg.ptr == `OFS_INTERRUPT_PENDING) begin
				rd_clr = s_reg.irq; // R8
			end
		end

		// Word writes
		if (wr_en) begin
			case (wa)
				`OFS_COMMAND_CONTROL: begin
					s_next.ctrl = wd;
					if (wd == `CMD_SHUTDOWN_SCL || wd == `CMD_SHUTDOWN_ALERT) begin
						s_next.sleep_pend = 1'b1; // R16
						s_next.wake_sel = wd[0]; // R16
					end
				end
				`OFS_THERMAL_READING: s_next.therm = wd;
				`OFS_ALERT_STATUS_ONE: sw_clr = EVT & ~wd[8:0]; // R4
				`OFS_ALERT_ENABLE: s_next.alert_en = wd[8:0]; // R12
				`OFS_IRQ_ENABLE: s_next.irq_en = wd[8:0]; // R10
				`OFS_GAUGE_COMP_A: s_next.comp_a = wd;
				`OFS_GAUGE_COMP_B: s_next.comp_b = wd;
				`OFS_CHARGE_ROUND_TALLY: s_next.tally = wd;
				// Extended command is accepted and has no effect here
				default: if (wa[7:4] == `EXT_WORDS_PAGE) begin
					s_next.ext[wa[3:1]] = wd;
				end
			endcase
		end

		// Flags follow the new enables, so a disable clears at once
		lvl = s_next.alert_en & cond_in & ~EVT; // R1 R2 R3 R11
		// Step flags: condition sets and wins over write-zero and pending-read clears
		evt = s_next.alert_en & EVT & (cond_in | (s_reg.flag & ~sw_clr & ~(rd_clr & EVT))); // R2 R4 R9 R11
		s_next.flag = lvl | evt;
		// Interrupts only on a change, so a flag already set raises nothing
		irq_set = s_reg.irq_en & ((~EVT & (s_next.flag ^ s_reg.flag)) | (EVT & s_next.flag & ~s_reg.flag)); // R5 R6 R7
		s_next.irq = (s_reg.irq & ~rd_clr) | irq_set; // R8 R10

		// Reset and wake both restore power-on values
		if (rst_in || wake) begin
			s_next = rst_v;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		s_reg <= s_next;
	end

	// Open-drain pins: only ever pulled low
	assign link.dev_sda_out = 1'b0;
	assign link.dev_sda_oe = s_reg.sda_oe & ~s_reg.asleep;
	assign link.dev_alert_out = 1'b0;
	assign link.dev_alert_oe = (|s_reg.irq) & ~s_reg.asleep; // R19
	assign shutdown_out = s_reg.asleep;

endmodule : gauge_alert_dev
`default_nettype wire

// *** logic/gauge_host_ctl.sv ***
/*
 Host end: serial controller at fast-mode rate plus wake pulses, run
 from a small command port. Assumes one gauge target with pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gauge_map.svh"

module gauge_host_ctl #(
	parameter logic [7:0] QUARTER_CYC = 8'(`I2C_QUARTER_CYC),
	parameter logic [15:0] WAKE_CYC = 16'(`WAKE_LOW_CYC)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	gauge_link_if.host link
);

	gauge_pkg::host_state_t s_reg; // Registered state
	gauge_pkg::host_state_t s_next; // Next state

	// Whole next-state function
	always_comb begin
		logic tick;
		logic recv;
		logic last;
		tick = (s_reg.div == 8'(QUARTER_CYC - 1));
		s_next = s_reg;
		s_next.div = tick ? 8'h00 : 8'(s_reg.div + 1); // R15
		recv = s_reg.op_rd & (s_reg.idx >= 3'h3);
		last = s_reg.op_rd ? (s_reg.idx == 3'h4) : (s_reg.idx == 3'h3);

		// Command port writes
		if (wr_in && addr_in == `HOST_OFS_WDATA) begin
			s_next.wdata = wdata_in;
		end
		if (wr_in && addr_in == `HOST_OFS_CMD && s_reg.st == gauge_pkg::hs_idle) begin
			if (wdata_in[`HCMD_WAKE_SCL] || wdata_in[`HCMD_WAKE_ALERT]) begin
				// Hold the chosen pin low, then let it rise
				s_next.st = gauge_pkg::hs_wake;
				s_next.scl_oe = wdata_in[`HCMD_WAKE_SCL]; // R16
				s_next.alert_oe = ~wdata_in[`HCMD_WAKE_SCL]; // R16
				s_next.wake_cnt = '0;
			end else if (wdata_in[`HCMD_GO]) begin
				s_next.st = gauge_pkg::hs_start;
				s_next.ph = '0;
				s_next.div = '0;
				s_next.idx = '0;
				s_next.op_rd = wdata_in[`HCMD_READ];
				s_next.ptr = wdata_in[7:0];
				s_next.sh = {`TARGET_ADDR, 1'b0};
				s_next.nack = 1'b0;
			end
		end

		// Command port reads, answered in the next cycle
		if (rd_in) begin
			case (addr_in)
				`HOST_OFS_STATUS: s_next.rd_out = {13'h0000, ~link.alert_line, s_reg.nack,
					s_reg.st != gauge_pkg::hs_idle}; // R13
				`HOST_OFS_RDATA: s_next.rd_out = s_reg.rdata;
				`HOST_OFS_WDATA: s_next.rd_out = s_reg.wdata;
				default: s_next.rd_out = '0;
			endcase
		end

		// Wake pulse counts plain cycles
		if (s_reg.st == gauge_pkg::hs_wake) begin
			s_next.wake_cnt = 16'(s_reg.wake_cnt + 1);
			if (s_reg.wake_cnt == 16'(WAKE_CYC - 1)) begin // R17
				s_next.scl_oe = 1'b0;
				s_next.alert_oe = 1'b0;
				s_next.st = gauge_pkg::hs_idle;
			end
		end else if (tick) begin
			// One quarter of a serial bit per step
			s_next.ph = 2'(s_reg.ph + 1);
			case (s_reg.st)
				gauge_pkg::hs_start: begin
					case (s_reg.ph)
						2'h0: s_next.sda_oe = 1'b0;
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: s_next.sda_oe = 1'b1;
						default: begin
							s_next.scl_oe = 1'b1;
							s_next.st = gauge_pkg::hs_bit;
							s_next.bit_i = '0;
						end
					endcase
				end
				gauge_pkg::hs_bit: begin
					case (s_reg.ph)
						// Data changes only while the clock is low
						2'h0: if (s_reg.bit_i == 4'h8) begin
							s_next.sda_oe = recv & (s_reg.idx != 3'h4);
						end else begin
							s_next.sda_oe = ~recv & ~s_reg.sh[7];
						end
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: if (s_reg.bit_i == 4'h8) begin
							if (!recv && link.sda_line) begin
								s_next.nack = 1'b1;
							end
							if (recv && s_reg.idx == 3'h3) begin
								s_next.rdata[7:0] = s_reg.sh;
							end
							if (recv && s_reg.idx == 3'h4) begin
								s_next.rdata[15:8] = s_reg.sh;
							end
						end else begin
							s_next.sh = {s_reg.sh[6:0], recv ? link.sda_line : 1'b0};
						end
						default: begin
							s_next.scl_oe = 1'b1;
							s_next.bit_i = 4'(s_reg.bit_i + 1);
							if (s_reg.bit_i == 4'h8) begin
								s_next.bit_i = '0;
								s_next.idx = 3'(s_reg.idx + 1);
								if (s_reg.nack || last) begin
									s_next.st = gauge_pkg::hs_stop;
								end else if (s_reg.op_rd && s_reg.idx == 3'h1) begin
									// Repeated start before the read
									s_next.st = gauge_pkg::hs_start;
									s_next.sh = {`TARGET_ADDR, 1'b1};
								end else if (s_reg.idx == 3'h0) begin
									s_next.sh = s_reg.ptr;
								end else begin
									s_next.sh = (s_reg.idx == 3'h1) ? s_reg.wdata[7:0] : s_reg.wdata[15:8];
								end
							end
						end
					endcase
				end
				gauge_pkg::hs_stop: begin
					case (s_reg.ph)
						2'h0: s_next.sda_oe = 1'b1;
						2'h1: s_next.scl_oe = 1'b0;
						2'h2: s_next.sda_oe = 1'b0;
						default: s_next.st = gauge_pkg::hs_idle;
					endcase
				end
				default: ;
			endcase
		end

		if (rst_in) begin
			s_next = '0;
			s_next.st = gauge_pkg::hs_idle;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		s_reg <= s_next;
	end

	// Open-drain drivers: low while enabled
	assign link.host_scl_out = 1'b0;
	assign link.host_scl_oe = s_reg.scl_oe;
	assign link.host_sda_out = 1'b0;
	assign link.host_sda_oe = s_reg.sda_oe;
	assign link.host_alert_out = 1'b0;
	assign link.host_alert_oe = s_reg.alert_oe;
	assign rdata_out = s_reg.rd_out;

endmodule : gauge_host_ctl
`default_nettype wire

// *** tb/gauge_link_assertions.sv ***
/*
 Checker for the gauge link: open-drain alert, quiet sleep, serial timing.
 Assumes the wires of gauge_link_if plus shutdown_out, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module gauge_link_assertions (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_line,
	input wire logic alert_line,
	input wire logic host_alert_oe,
	input wire logic dev_sda_oe,
	input wire logic dev_alert_oe,
	input wire logic shutdown_out
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_alert_pulls_low: assert property (dev_alert_oe |-> !alert_line)
		else $error("alert line high while pending");
	a_alert_idle_high: assert property (!dev_alert_oe && !host_alert_oe |-> alert_line)
		else $error("alert line low with nobody driving");
	a_sleep_no_data: assert property (shutdown_out |-> !dev_sda_oe)
		else $error("data driven while asleep");
	a_sleep_no_alert: assert property (shutdown_out |-> !dev_alert_oe)
		else $error("alert driven while asleep");
	// Data may only turn while the clock is low
	a_data_on_low: assert property ($changed(dev_sda_oe) |-> !scl_line)
		else $error("data changed with clock high");
	a_clock_high_min: assert property ($rose(scl_line) |-> scl_line [*4])
		else $error("clock high phase too short");
	a_clock_low_min: assert property ($fell(scl_line) |-> !scl_line [*4])
		else $error("clock low phase too short");
	// Wake only on a rising line, so both lines are high then
	a_wake_on_rise: assert property ($fell(shutdown_out) |-> scl_line && alert_line)
		else $error("woke without a rising wake line");
endmodule : gauge_link_assertions
`default_nettype wire

// *** tb/gauge_alert_irq_and_register_map_tb.sv ***
/*
 Bench for both link ends: command port drives the host, cond_in the gauge.
 Assumes the package, interface and both design ends compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gauge_map.svh"
module gauge_alert_irq_and_register_map_tb;
	logic clk_in, rst_in, wr_in, rd_in, chk_rd, chk_d, shutdown_out;
	logic [3:0] addr_in;
	logic [15:0] wdata_in, rdata_out, tmp, rv, wv;
	logic [8:0] cond_in;
	logic [15:0] exp_q [$]; // Expected read words, oldest first
	logic [23:0] rst_tab [6] = '{24'h06_0ba6, 24'h08_0ed8, 24'h10_03e8, 24'h16_ffff, 24'h2c_0032, 24'h40_ffff};
	int fail_count, total_checks, i;
	int seed = 32'hf720;

	gauge_link_if link();
	gauge_alert_dev #(.WAKE_CYC(16'h0008)) gauge_alert_dev_inst (.clk_in(clk_in), .rst_in(rst_in),
		.cond_in(cond_in), .shutdown_out(shutdown_out), .link(link.device));
	// Short quarter bit keeps frames cheap
	gauge_host_ctl #(.QUARTER_CYC(8'h04), .WAKE_CYC(16'h0008)) gauge_host_ctl_inst (.clk_in(clk_in),
		.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .link(link.host));
	gauge_link_assertions gauge_link_assertions_inst (.clk_in(clk_in), .rst_in(rst_in),
		.scl_line(link.scl_line), .alert_line(link.alert_line), .host_alert_oe(link.host_alert_oe),
		.dev_sda_oe(link.dev_sda_oe), .dev_alert_oe(link.dev_alert_oe), .shutdown_out(shutdown_out));

	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] e);
		total_checks++;
		if (got !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : cmp

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Command port write, one-cycle strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	// Command port read; chk marks it for the monitor
	task automatic rd(input logic [3:0] a, input logic chk, output logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		chk_rd <= chk;
		@(posedge clk_in);
		rd_in <= 1'b0;
		chk_rd <= 1'b0;
		@(posedge clk_in);
		d = rdata_out;
	endtask : rd

	// Launch a serial transfer and poll busy, bounded
	task automatic dev_op(input logic [15:0] cmd, input logic [15:0] d);
		wr(`HOST_OFS_WDATA, d);
		wr(`HOST_OFS_CMD, cmd);
		rv = 16'h0001;
		for (int n = 0; n < 2000 && rv[0] !== 1'b0; n++) begin
			rd(`HOST_OFS_STATUS, 1'b0, rv);
		end
		// Busy that never drops is a hang: count it and stop
		if (rv[0] !== 1'b0) begin
			fail_count++;
			wrap_up();
		end
	endtask : dev_op

	task automatic dw(input logic [7:0] p, input logic [15:0] d);
		dev_op({8'h02, p}, d);
	endtask : dw

	// Device read, expected word noted before the answer can appear
	task automatic dr(input logic [7:0] p, input logic [15:0] e);
		dev_op({8'h03, p}, 16'h0000);
		exp_q.push_back(e);
		rd(`HOST_OFS_RDATA, 1'b1, tmp);
	endtask : dr

	// Host status: bit1 no answer, bit2 alert line low
	task automatic hs(input logic [15:0] e);
		exp_q.push_back(e);
		rd(`HOST_OFS_STATUS, 1'b1, tmp);
	endtask : hs

	// Monitor: a marked read's word stands one cycle after the strobe
	always @(posedge clk_in) begin
		if (chk_d && exp_q.size() > 0) begin
			cmp(rdata_out, exp_q.pop_front());
		end
		chk_d <= rd_in & chk_rd;
	end

	// Hang guard, well above the expected run length
	initial begin
		repeat (90000) @(posedge clk_in);
		fail_count++;
		wrap_up();
	end

	initial begin
		{rst_in, wr_in, rd_in, chk_rd} = 4'h8;
		{addr_in, wdata_in, cond_in} = '0;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		// Printed reset values, then a random write-back
		for (i = 0; i < 6; i++) begin
			dr(rst_tab[i][23:16], rst_tab[i][15:0]);
		end
		wv = 16'($random(seed));
		dw(`OFS_GAUGE_COMP_A, wv);
		dr(`OFS_GAUGE_COMP_A, wv);
		// Level alerts
		cond_in <= 9'h1ff;
		dr(`OFS_ALERT_STATUS_ONE, 16'h0000);
		dw(`OFS_ALERT_ENABLE, 16'h01ff);
		dr(`OFS_ALERT_STATUS_ONE, 16'h01ff);
		cond_in <= 9'h004;
		dr(`OFS_ALERT_STATUS_ONE, 16'h0124);
		dw(`OFS_IRQ_ENABLE, 16'h01ff);
		hs(16'h0000);
		cond_in <= 9'h000;
		hs(16'h0004);
		dr(`OFS_INTERRUPT_PENDING, 16'h0004);
		hs(16'h0000);
		dw(`OFS_ALERT_STATUS_ONE, 16'h0000);
		dr(`OFS_ALERT_STATUS_ONE, 16'h0000);
		// Step alert from a one-cycle pulse
		cond_in <= 9'h020;
		@(posedge clk_in);
		cond_in <= 9'h000;
		dr(`OFS_ALERT_STATUS_ONE, 16'h0020);
		dr(`OFS_INTERRUPT_PENDING, 16'h0020);
		dr(`OFS_ALERT_STATUS_ONE, 16'h0000);
		// Pending survives a dropped interrupt enable
		cond_in <= 9'h008;
		dw(`OFS_IRQ_ENABLE, 16'h0000);
		hs(16'h0004);
		dr(`OFS_INTERRUPT_PENDING, 16'h0008);
		dw(`OFS_ALERT_ENABLE, 16'h0000);
		dr(`OFS_ALERT_STATUS_ONE, 16'h0000);
		cond_in <= 9'h000;
		// Shutdown and wake, by clock line then by alert line
		for (i = 0; i < 2; i++) begin
			wv = 16'($random(seed));
			dw(`OFS_THERMAL_READING, wv);
			dr(`OFS_THERMAL_READING, wv);
			dw(`OFS_COMMAND_CONTROL, `CMD_SHUTDOWN_SCL | 16'(i));
			repeat (4) @(posedge clk_in);
			cmp({15'h0000, shutdown_out}, 16'h0001);
			dev_op({8'h03, `OFS_CELL_VOLTAGE}, 16'h0000);
			hs(16'h0002);
			dev_op((i == 0) ? 16'h0400 : 16'h0800, 16'h0000);
			repeat (4) @(posedge clk_in);
			cmp({15'h0000, shutdown_out}, 16'h0000);
			dr(`OFS_THERMAL_READING, `RST_THERMAL);
		end
		wrap_up();
	end
endmodule : gauge_alert_irq_and_register_map_tb
`default_nettype wire
